// >>> src/rlsm_unit.sv
// Logic, shift, load/store and branch execution unit with APB access
`timescale 1ns/1ps
module rlsm_unit (
  // Clock and reset
  input wire logic sys_clk_in,
  input wire logic sys_rst_in,
  // APB slave
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [rlsm_pkg::APB_ADDR_W-1:0] paddr_in,
  input wire logic [rlsm_pkg::DATA_W-1:0] pwdata_in,
  output logic [rlsm_pkg::DATA_W-1:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out,
  // Data memory port
  output rlsm_pkg::rlsm_mem_req_t mem_req_out,
  input wire logic [rlsm_pkg::DATA_W-1:0] mem_rdata_in,
  input wire logic mem_ack_in
);
  import rlsm_pkg::*;

  ////////////////////////////////////////////////////////////////////
  // Decode helpers

  function automatic logic in_reg_window(
    input logic [APB_ADDR_W-1:0] a
  );
    in_reg_window = (a >= OFF_REGS) && (a <= OFF_REGS_END);
  endfunction : in_reg_window

  function automatic logic is_mapped(input logic [APB_ADDR_W-1:0] a);
    is_mapped = in_reg_window(a) || (a == OFF_CMD) ||
                (a == OFF_IMM) || (a == OFF_PC) || (a == OFF_STATUS);
  endfunction : is_mapped

  ////////////////////////////////////////////////////////////////////
  // State

  // Sixteen words; r14 stack_top_register, r15 return_link_register
  // architectural register file
  logic [DATA_W-1:0] regs_r [NUM_REGS];
  logic [DATA_W-1:0] pc_r;
  logic [DATA_W-1:0] pc_nxt;
  logic [DATA_W-1:0] imm_r;
  rlsm_cmd_t cmd_r;
  rlsm_flags_t flags_r;
  rlsm_state_t state_r;
  rlsm_mem_req_t mem_req_r;
  logic pready_r;
  logic pslverr_r;
  logic [DATA_W-1:0] prdata_r;

  ////////////////////////////////////////////////////////////////////
  // APB slave

  logic access;
  logic apb_wr;
  logic apb_rd_mux_hit;
  logic [REG_IDX_W-1:0] apb_reg_idx;
  logic [DATA_W-1:0] rd_mux;
  rlsm_status_t status;

  assign access = psel_in && penable_in;
  assign apb_wr = access && pwrite_in && pready_r;
  assign apb_reg_idx = paddr_in[REG_SEL_LSB +: REG_IDX_W];
  assign apb_rd_mux_hit = is_mapped(paddr_in);

  always_comb
  begin
    status = '0;
    status.busy = (state_r != PH_IDLE);
    status.equal_flag = flags_r.equal_flag;
    status.greater_flag = flags_r.greater_flag;
  end

  always_comb
  begin
    rd_mux = RESET_WORD;
    if (in_reg_window(paddr_in))
    begin
      rd_mux = regs_r[apb_reg_idx];
    end
    else
    begin
      case (paddr_in)
        OFF_CMD: rd_mux = cmd_r;
        OFF_IMM: rd_mux = imm_r;
        OFF_PC: rd_mux = pc_r;
        OFF_STATUS: rd_mux = status;
        default: rd_mux = RESET_WORD;
      endcase
    end
  end

  // Answer one cycle into the access phase, only while idle
  always_ff @(posedge sys_clk_in)
  begin
    if (sys_rst_in)
    begin
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r <= RESET_WORD;
    end
    else
    begin
      pready_r <= access && !pready_r && (state_r == PH_IDLE);
      pslverr_r <= access && !pready_r && (state_r == PH_IDLE) &&
                   !apb_rd_mux_hit;
      if (access && !pready_r && !pwrite_in)
      begin
        prdata_r <= rd_mux;
      end
    end
  end

  assign pready_out = pready_r;
  assign pslverr_out = pslverr_r;
  assign prdata_out = prdata_r;

  always_ff @(posedge sys_clk_in)
  begin
    if (sys_rst_in)
    begin
      cmd_r <= '0;
      imm_r <= RESET_WORD;
    end
    else if (apb_wr && paddr_in == OFF_CMD)
    begin
      cmd_r <= rlsm_cmd_t'(pwdata_in);
    end
    else if (apb_wr && paddr_in == OFF_IMM)
    begin
      imm_r <= pwdata_in;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Operands and result

  logic [DATA_W-1:0] src_a;
  logic [DATA_W-1:0] src_b;
  logic [SHAMT_W-1:0] shamt;
  logic [DATA_W-1:0] alu_res;
  logic alu_wr;
  logic [DATA_W-1:0] seq_pc;
  logic [DATA_W-1:0] mem_addr;
  logic is_mem_op;

  assign src_a = regs_r[cmd_r.rs1];
  assign src_b = cmd_r.use_imm ? imm_r : regs_r[cmd_r.rs2];
  assign shamt = src_b[SHAMT_W-1:0];
  assign seq_pc = pc_r + INSTR_BYTES;
  assign mem_addr = src_a + imm_r;
  assign is_mem_op = (cmd_r.op == OP_MEMORY_READ) ||
                     (cmd_r.op == OP_MEMORY_WRITE);

  always_comb
  begin
    alu_res = RESET_WORD;
    alu_wr = 1'b1;
    pc_nxt = seq_pc;
    case (cmd_r.op)
      OP_AND: alu_res = src_a & src_b;
      OP_OR: alu_res = src_a | src_b;
      OP_NOT: alu_res = ~src_b;
      OP_LSL: alu_res = src_a << shamt;
      OP_LSR: alu_res = src_a >> shamt;
      OP_ASR: alu_res = DATA_W'($signed(src_a) >>> shamt);
      OP_BRANCH:
      begin
        alu_wr = 1'b0;
        pc_nxt = imm_r;
      end
      OP_BRANCH_EQ:
      begin
        alu_wr = 1'b0;
        pc_nxt = flags_r.equal_flag ? imm_r : seq_pc;
      end
      OP_BRANCH_GT:
      begin
        alu_wr = 1'b0;
        pc_nxt = flags_r.greater_flag ? imm_r : seq_pc;
      end
      OP_CALL:
      begin
        alu_res = seq_pc;
        pc_nxt = imm_r;
      end
      OP_RETURN:
      begin
        alu_wr = 1'b0;
        pc_nxt = regs_r[RETURN_LINK_IDX];
      end
      default:
      begin
        // compare and unknown codes fall through
        alu_wr = 1'b0;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////
  // Sequencing

  logic mem_done;
  assign mem_done = (state_r == PH_MEM) && mem_ack_in;

  always_ff @(posedge sys_clk_in)
  begin
    if (sys_rst_in)
    begin
      state_r <= PH_IDLE;
    end
    else
    begin
      case (state_r)
        PH_IDLE:
        begin
          if (apb_wr && paddr_in == OFF_CMD)
            state_r <= PH_EXEC;
        end
        PH_EXEC: state_r <= is_mem_op ? PH_MEM : PH_IDLE;
        PH_MEM:
        begin
          if (mem_ack_in)
            state_r <= PH_IDLE;
        end
        default: state_r <= PH_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Program counter

  always_ff @(posedge sys_clk_in)
  begin
    if (sys_rst_in)
      pc_r <= RESET_WORD;
    else if (apb_wr && paddr_in == OFF_PC)
      pc_r <= pwdata_in;
    else if (state_r == PH_EXEC && !is_mem_op)
      pc_r <= pc_nxt;
    else if (mem_done)
    begin
      pc_r <= seq_pc;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Flags

  always_ff @(posedge sys_clk_in)
  begin
    if (sys_rst_in)
    begin
      flags_r <= '0;
    end
    else if (state_r == PH_EXEC && cmd_r.op == OP_CMP)
    begin
      flags_r.equal_flag <= ((src_a - src_b) == RESET_WORD);
      flags_r.greater_flag <= ($signed(src_a) > $signed(src_b));
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Register file

  logic [REG_IDX_W-1:0] wb_idx;
  assign wb_idx = (cmd_r.op == OP_CALL) ? RETURN_LINK_IDX : cmd_r.rd;

  always_ff @(posedge sys_clk_in)
  begin
    if (sys_rst_in)
    begin
      for (int i = 0; i < NUM_REGS; i++)
      begin
        regs_r[i] <= RESET_WORD;
      end
    end
    else if (apb_wr && in_reg_window(paddr_in))
    begin
      regs_r[apb_reg_idx] <= pwdata_in;
    end
    else if (state_r == PH_EXEC && !is_mem_op && alu_wr)
    begin
      regs_r[wb_idx] <= alu_res;
    end
    else if (mem_done && !mem_req_r.we)
    begin
      // lane 0 is the lowest-addressed byte
      regs_r[cmd_r.rd] <= mem_rdata_in;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Memory request

  always_ff @(posedge sys_clk_in)
  begin
    if (sys_rst_in)
    begin
      mem_req_r <= '0;
    end
    else if (state_r == PH_EXEC && is_mem_op)
    begin
      mem_req_r.valid <= 1'b1;
      mem_req_r.we <= (cmd_r.op == OP_MEMORY_WRITE);
      mem_req_r.addr <= mem_addr;
      // store rd, same byte order as loads
      mem_req_r.wdata <= regs_r[cmd_r.rd];
    end
    else if (mem_done)
    begin
      mem_req_r.valid <= 1'b0;
    end
  end

  assign mem_req_out = mem_req_r;

endmodule : rlsm_unit

// >>> src/rlsm_pkg.sv
// Constants, types and layouts of the logic/shift/memory/branch unit
// Summary of operation
// - And/or: rs1 combined with register or immediate
// - Complement writes inverse of its source
// - Complement source is register or immediate
// - Left shift of rs1 by amount
// - Logical right shift fills zeros
// - Arithmetic right shift replicates sign bit
// - Shift amount from register or immediate
// - Load: base plus signed offset into rd
// - Addressed byte is least significant byte
// - Store rd to base plus offset
// - Branch loads target into program counter
// - Branch if equal flag, else next
// - Branch if greater flag, else next
// - Call jumps, return address is pc+4
// - Call writes return address into r15
// - Every call overwrites the return register
// - Return loads pc from r15
// - Sixteen 32-bit registers; r14 stack, r15 return
// - Equal and greater flags, reset zero
// - Compare sets equal and greater flags
// - Instructions are four bytes
package rlsm_pkg;

  localparam int DATA_W = 32;
  localparam int NUM_REGS = 16;
  localparam int REG_IDX_W = 4;
  localparam int SHAMT_W = 5;
  localparam int APB_ADDR_W = 12;
  localparam int REG_SEL_LSB = 2;

  localparam logic [REG_IDX_W-1:0] STACK_TOP_IDX = 4'he;
  localparam logic [REG_IDX_W-1:0] RETURN_LINK_IDX = 4'hf;
  localparam logic [DATA_W-1:0] INSTR_BYTES = 32'h0000_0004;
  localparam logic [DATA_W-1:0] RESET_WORD = 32'h0000_0000;

  // Register map, byte addresses
  localparam logic [APB_ADDR_W-1:0] OFF_CMD = 12'h000;
  localparam logic [APB_ADDR_W-1:0] OFF_IMM = 12'h004;
  localparam logic [APB_ADDR_W-1:0] OFF_PC = 12'h008;
  localparam logic [APB_ADDR_W-1:0] OFF_STATUS = 12'h00c;
  localparam logic [APB_ADDR_W-1:0] OFF_REGS = 12'h040;
  localparam logic [APB_ADDR_W-1:0] OFF_REGS_END = 12'h07c;

  // Operation codes
  localparam logic [3:0] OP_AND = 4'h0;
  localparam logic [3:0] OP_OR = 4'h1;
  localparam logic [3:0] OP_NOT = 4'h2;
  localparam logic [3:0] OP_LSL = 4'h3;
  localparam logic [3:0] OP_LSR = 4'h4;
  localparam logic [3:0] OP_ASR = 4'h5;
  localparam logic [3:0] OP_MEMORY_READ = 4'h6;
  localparam logic [3:0] OP_MEMORY_WRITE = 4'h7;
  localparam logic [3:0] OP_BRANCH = 4'h8;
  localparam logic [3:0] OP_BRANCH_EQ = 4'h9;
  localparam logic [3:0] OP_BRANCH_GT = 4'ha;
  localparam logic [3:0] OP_CALL = 4'hb;
  localparam logic [3:0] OP_RETURN = 4'hc;
  localparam logic [3:0] OP_CMP = 4'hd;

  typedef struct packed {
    logic [14:0] pad;
    logic use_imm;
    logic [REG_IDX_W-1:0] rs2;
    logic [REG_IDX_W-1:0] rs1;
    logic [REG_IDX_W-1:0] rd;
    logic [3:0] op;
  } rlsm_cmd_t;

  typedef struct packed {
    logic [28:0] pad;
    logic greater_flag;
    logic equal_flag;
    logic busy;
  } rlsm_status_t;

  typedef struct packed {
    logic equal_flag;
    logic greater_flag;
  } rlsm_flags_t;

  // Byte k of data sits at address addr+k
  typedef struct packed {
    logic valid;
    logic we;
    logic [DATA_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } rlsm_mem_req_t;

  typedef enum logic [1:0] {PH_IDLE, PH_EXEC, PH_MEM} rlsm_state_t;

endpackage : rlsm_pkg

// >>> testbench/rlsm_unit_assertions.sv
// Port checker for the execution unit
`timescale 1ns/1ps
module rlsm_unit_checker (
  // Clock, reset and APB
  input wire logic sys_clk_in,
  input wire logic sys_rst_in,
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [rlsm_pkg::APB_ADDR_W-1:0] paddr_in,
  input wire logic [rlsm_pkg::DATA_W-1:0] pwdata_in,
  input wire logic [rlsm_pkg::DATA_W-1:0] prdata_out,
  input wire logic pready_out,
  input wire logic pslverr_out,
  // Memory port
  input wire rlsm_pkg::rlsm_mem_req_t mem_req_out,
  input wire logic [rlsm_pkg::DATA_W-1:0] mem_rdata_in,
  input wire logic mem_ack_in
);
  import rlsm_pkg::*;
  default clocking @(posedge sys_clk_in); endclocking
  default disable iff (sys_rst_in);
  logic cmd_wr;
  logic mapped;
  assign cmd_wr = psel_in && penable_in && pready_out && pwrite_in
    && paddr_in == OFF_CMD;
  assign mapped = paddr_in < 12'h010
    || (paddr_in >= OFF_REGS && paddr_in <= OFF_REGS_END);
  ready_in_access_a: assert property (pready_out |-> psel_in && penable_in)
    else $error("ready outside access phase");
  ready_pulse_a: assert property (pready_out |=> !pready_out)
    else $error("ready longer than one cycle");
  err_with_ready_a: assert property (pslverr_out |-> pready_out)
    else $error("error without ready");
  map_err_a: assert property (
    pready_out && paddr_in[1:0] == 2'h0 |-> pslverr_out == !mapped)
    else $error("wrong error for address");
  busy_hold_a: assert property (mem_req_out.valid |-> !pready_out)
    else $error("bus answered during memory access");
  req_stable_a: assert property (
    mem_req_out.valid && !mem_ack_in |=> $stable(mem_req_out))
    else $error("request changed before ack");
  req_drop_a: assert property (mem_req_out.valid && mem_ack_in |=>
    !mem_req_out.valid) else $error("request kept after ack");
  load_req_a: assert property (
    cmd_wr && pwdata_in[3:0] == OP_MEMORY_READ
    |-> ##[1:3] mem_req_out.valid && !mem_req_out.we)
    else $error("no read request after load");
  store_req_a: assert property (
    cmd_wr && pwdata_in[3:0] == OP_MEMORY_WRITE
    |-> ##[1:3] mem_req_out.valid && mem_req_out.we)
    else $error("no write request after store");
  no_mem_a: assert property (cmd_wr && pwdata_in[3:0] < OP_MEMORY_READ
    |=> !mem_req_out.valid [*3]) else $error("memory used by logic op");
endmodule : rlsm_unit_checker
bind rlsm_unit rlsm_unit_checker chk_i (.sys_clk_in, .sys_rst_in, .psel_in,
  .penable_in, .pwrite_in, .paddr_in, .pwdata_in, .prdata_out, .pready_out,
  .pslverr_out, .mem_req_out, .mem_rdata_in, .mem_ack_in);

// >>> testbench/rlsm_mem_model.sv
// Byte-addressed data memory model
`timescale 1ns/1ps
module rlsm_mem_model (
  // Clock and reset
  input wire logic sys_clk_in,
  input wire logic sys_rst_in,
  // Request side
  input wire rlsm_pkg::rlsm_mem_req_t req_in,
  input wire logic [3:0] wait_in,
  output logic [rlsm_pkg::DATA_W-1:0] rdata_out,
  output logic ack_out
);
  import rlsm_pkg::*;
  logic [7:0] mem [0:255];
  logic [3:0] cnt_r;
  always_ff @(posedge sys_clk_in)
  begin
    ack_out <= 1'b0;
    rdata_out <= ~rdata_out;
    if (sys_rst_in)
    begin
      cnt_r <= 4'h0;
      rdata_out <= 32'h0;
    end
    else if (req_in.valid && !ack_out)
    begin
      cnt_r <= cnt_r + 4'h1;
      if (cnt_r == wait_in)
      begin
        ack_out <= 1'b1;
        cnt_r <= 4'h0;
        for (int k = 0; k < 4; k++)
        begin
          if (req_in.we)
            mem[8'(req_in.addr[7:0] + k)] <= req_in.wdata[8*k +: 8];
          rdata_out[8*k +: 8] <= mem[8'(req_in.addr[7:0] + k)];
        end
      end
    end
  end
endmodule : rlsm_mem_model

// >>> testbench/rlsm_unit_tb.sv
// Self-checking bench for the execution unit
`timescale 1ns/1ps
module rlsm_unit_tb;
  import rlsm_pkg::*;
  logic sys_clk_in = 1'b0;
  logic sys_rst_in = 1'b1;
  logic psel_in = 1'b0;
  logic penable_in = 1'b0;
  logic pwrite_in = 1'b0;
  logic [11:0] paddr_in = 12'h000;
  logic [31:0] pwdata_in = 32'h0;
  logic [31:0] prdata_out;
  logic pready_out;
  logic pslverr_out;
  rlsm_mem_req_t mreq;
  logic [31:0] mrd;
  logic mack;
  logic [3:0] mwait = 4'h0;
  logic err_q;
  logic [31:0] q;
  int error_cnt = 0;
  int check_count = 0;
  always #5 sys_clk_in = ~sys_clk_in;
  rlsm_unit uut (.sys_clk_in, .sys_rst_in, .psel_in, .penable_in,
    .pwrite_in, .paddr_in, .pwdata_in, .prdata_out, .pready_out,
    .pslverr_out, .mem_req_out(mreq), .mem_rdata_in(mrd), .mem_ack_in(mack));
  rlsm_mem_model mem_i (.sys_clk_in, .sys_rst_in, .req_in(mreq),
    .wait_in(mwait), .rdata_out(mrd), .ack_out(mack));
  ////////////////////////////////////////////////////////////////////////////
  task finish_test;
    $display("errors=%0d checks=%0d", error_cnt, check_count);
    if (error_cnt == 0 && check_count > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : finish_test
  task chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge sys_clk_in);
    psel_in <= 1'b1;
    pwrite_in <= w;
    paddr_in <= a;
    pwdata_in <= d;
    @(posedge sys_clk_in);
    penable_in <= 1'b1;
    // Pready read just after an edge is the value that edge sampled
    do
    begin
      @(posedge sys_clk_in);
      n++;
    end
    while (pready_out !== 1'b1 && n < 500);
    if (pready_out !== 1'b1)
    begin
      error_cnt++;
      finish_test();
    end
    else
    begin
      q = prdata_out;
      err_q = pslverr_out;
      psel_in <= 1'b0;
      penable_in <= 1'b0;
    end
  endtask : apb
  function logic [31:0] mk(input logic [3:0] op, input logic [12:0] f);
    return {15'h0, f, op};
  endfunction : mk
  task wr(input logic [3:0] i, input logic [31:0] v);
    apb(1'b1, OFF_REGS + {6'h0, i, 2'h0}, v);
  endtask : wr
  task rd(input logic [3:0] i);
    apb(1'b0, OFF_REGS + {6'h0, i, 2'h0}, 32'h0);
  endtask : rd
  task step(input logic [31:0] c, input logic [31:0] e);
    apb(1'b1, OFF_CMD, c);
    apb(1'b0, OFF_PC, 32'h0);
    chk(q, e);
  endtask : step
  ////////////////////////////////////////////////////////////////////////////
  task t_logic;
    logic [31:0] a;
    logic [31:0] b;
    logic [31:0] e;
    a = 32'h8000_00f0;
    apb(1'b0, OFF_STATUS, 32'h0);
    chk(q, 32'h0);
    wr(4'h1, a);
    wr(4'h2, 32'h0000_0024);
    apb(1'b1, OFF_IMM, 32'h0000_0ff3);
    for (int i = 0; i < 12; i++)
    begin
      b = i[0] ? 32'h0000_0ff3 : 32'h0000_0024;
      case (i / 2)
        0: e = a & b;
        1: e = a | b;
        2: e = ~b;
        3: e = a << b[4:0];
        4: e = a >> b[4:0];
        default: e = $signed(a) >>> b[4:0];
      endcase
      apb(1'b1, OFF_CMD, mk(4'(i / 2), {i[0], 12'h213}));
      rd(4'h3);
      chk(q, e);
    end
    apb(1'b0, OFF_PC, 32'h0);
    chk(q, 32'h30);
  endtask : t_logic
  task t_mem;
    wr(4'h4, 32'h100);
    apb(1'b1, OFF_IMM, 32'hffff_fffc);
    step(mk(OP_MEMORY_WRITE, 13'h041), 32'h34);
    chk({mem_i.mem[255], mem_i.mem[254], mem_i.mem[253], mem_i.mem[252]},
      32'h8000_00f0);
    mwait <= 4'h5;
    step(mk(OP_MEMORY_READ, 13'h045), 32'h38);
    rd(4'h5);
    chk(q, 32'h8000_00f0);
  endtask : t_mem
  task t_branch;
    apb(1'b1, OFF_PC, 32'h20);
    apb(1'b1, OFF_IMM, 32'h300);
    step(mk(OP_BRANCH, 13'h0), 32'h300);
    step(mk(OP_CMP, 13'h110), 32'h304);
    apb(1'b0, OFF_STATUS, 32'h0);
    chk(q, 32'h2);
    step(mk(OP_BRANCH_EQ, 13'h0), 32'h300);
    step(mk(OP_BRANCH_GT, 13'h0), 32'h304);
    step(mk(OP_CMP, 13'h120), 32'h308);
    apb(1'b0, OFF_STATUS, 32'h0);
    chk(q, 32'h4);
    step(mk(OP_BRANCH_EQ, 13'h0), 32'h30c);
    step(mk(OP_BRANCH_GT, 13'h0), 32'h300);
  endtask : t_branch
  task t_call;
    apb(1'b1, OFF_IMM, 32'h500);
    step(mk(OP_CALL, 13'h0), 32'h500);
    rd(4'hf);
    chk(q, 32'h304);
    step(mk(OP_CALL, 13'h0), 32'h500);
    rd(4'hf);
    chk(q, 32'h504);
    step(mk(OP_RETURN, 13'h0), 32'h504);
    step(mk(4'he, 13'h0), 32'h508);
    apb(1'b0, 12'h080, 32'h0);
    chk({31'h0, err_q}, 32'h1);
    chk(q, 32'h0);
  endtask : t_call
  task t_reset;
    @(posedge sys_clk_in);
    sys_rst_in <= 1'b1;
    repeat (2) @(posedge sys_clk_in);
    sys_rst_in <= 1'b0;
    apb(1'b0, OFF_STATUS, 32'h0);
    chk(q, 32'h0);
    rd(4'hf);
    chk(q, 32'h0);
  endtask : t_reset
  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (12) @(posedge sys_clk_in);
    sys_rst_in <= 1'b0;
    t_logic();
    t_mem();
    t_branch();
    t_call();
    t_reset();
    finish_test();
  end
endmodule : rlsm_unit_tb
